// *** bench/aps_cap_model.sv ***
`timescale 1ns/100ps
module aps_cap_model (
  input  wire        core_clk,
  input  wire [5:0]  hi_w,
  input  wire [11:0] code,
  input  wire        flag,
  output reg         conv_clk,
  output reg  [12:0] cap_q
);
  reg [5:0] cnt_q = 6'h00;
  initial conv_clk = 1'b0;
  // Both phases last hi_w+1 cycles; bad widths are only asked for to provoke the monitor.
  always @(posedge core_clk) begin
    cnt_q <= (cnt_q >= hi_w) ? 6'h00 : cnt_q + 6'h01;
    if (cnt_q >= hi_w) conv_clk <= #1 ~conv_clk;
    if (!conv_clk && cnt_q >= hi_w) cap_q <= {flag, code};
  end
endmodule // aps_cap_model

// *** bench/aps_top_assertions.sv ***
`timescale 1ns/100ps
module aps_chk (
  input wire        core_clk,
  input wire        rst,
  input wire        conv_clk,
  input wire [13:0] analog_sample_input,
  input wire [11:0] sample_code_bits,
  input wire        overrange_flag,
  input wire        clock_high_width_err
);
  reg        cv_q;
  reg        v_q;
  reg [13:0] in_q;
  reg [12:0] e_q;
  wire       rise = conv_clk && !cv_q;
  wire [12:0] e_d = (!in_q[13] && |in_q[12:11]) ? 13'h1fff :
                    (in_q[13] && ~&in_q[12:11]) ? 13'h0000 : {1'b0, ~in_q[11], in_q[10:0]};
  always @(posedge core_clk) begin
    cv_q <= rst ? 1'b0 : conv_clk;
    v_q <= rst ? 1'b0 : (v_q | rise);
    if (rise) in_q <= analog_sample_input;
    if (rise) e_q <= e_d;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  latency_code_a: assert property (rise && v_q |=> sample_code_bits == e_q[11:0])
    else $error("code does not match the previous sample");
  ovr_flag_a: assert property (rise && v_q |=> overrange_flag == e_q[12])
    else $error("overrange flag wrong");
  ovr_max_a: assert property (overrange_flag |-> sample_code_bits == 12'hfff)
    else $error("code not saturated in overrange");
  width_clear_a: assert property (rise |=> !clock_high_width_err)
    else $error("width error not cleared at a rise");
  short_high_a: assert property (rise ##1 !conv_clk |=> clock_high_width_err)
    else $error("short high phase not reported");
  hold_code_a: assert property (!$past(rise) && !$past(rst) |-> $stable(sample_code_bits))
    else $error("code changed between rises");
  hold_flag_a: assert property (!$past(rise) && !$past(rst) |-> $stable(overrange_flag))
    else $error("flag changed between rises");
  reset_clear_a: assert property ($past(rst) |-> sample_code_bits == 12'h000 && !overrange_flag)
    else $error("outputs not cleared by reset");
endmodule // aps_chk
bind aps_top aps_chk aps_chk_inst (.core_clk, .rst, .conv_clk, .analog_sample_input,
  .sample_code_bits, .overrange_flag, .clock_high_width_err);

// *** bench/tb_adc_parallel_sample_output.sv ***
`timescale 1ns/100ps
module tb_adc_parallel_sample_output;
  reg         core_clk = 1'b0;
  reg         rst = 1'b1;
  reg  [13:0] ain = 14'h0000;
  reg  [13:0] cur = 14'h3800;
  reg  [13:0] prev;
  reg  [13:0] prev2;
  reg  [5:0]  hi_w = 6'h03;
  reg  [31:0] v;
  reg         seen;
  integer     seed = 32'h6873f6db;
  integer     mismatches = 0;
  integer     tests_run = 0;
  integer     p;
  integer     i;
  wire        conv_clk;
  wire [11:0] code;
  wire        flag;
  wire        err;
  wire [12:0] cap;
  aps_top aps_top_inst (.core_clk(core_clk), .rst(rst), .conv_clk(conv_clk),
    .analog_sample_input(ain), .sample_code_bits(code), .overrange_flag(flag),
    .clock_high_width_err(err));
  aps_cap_model aps_cap_model_inst (.core_clk(core_clk), .hi_w(hi_w), .code(code),
    .flag(flag), .conv_clk(conv_clk), .cap_q(cap));
  initial forever #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (err === 1'b1) seen = 1'b1;
  function [12:0] f(input [13:0] x);
    f = (!x[13] && |x[12:11]) ? 13'h1fff :
        (x[13] && ~&x[12:11]) ? 13'h0000 : {1'b0, ~x[11], x[10:0]};
  endfunction
  task chk(input [39:0] nm, input [12:0] s, input [12:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("BAD %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    // The three tests need about 1300 clock cycles; this allows several times that.
    #50000;
    mismatches = mismatches + 1;
    results;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    for (p = 0; p < 3; p = p + 1) begin
      hi_w = (p == 0) ? 6'h03 : (p == 1) ? 6'h28 : 6'h00;
      seen = 1'b0;
      for (i = 0; i < 14; i = i + 1) begin
        @(posedge conv_clk);
        v = $random(seed);
        prev2 = prev;
        prev = cur;
        cur = v[14] ? {{2{v[11]}}, v[11:0]} : v[13:0];
        if (p == 0 && i < 8) cur = {14'h0800, 14'h07ff, 14'h3800, 14'h37ff,
          14'h0000, 14'h1fff, 14'h2000, 14'h0001} >> (14 * (7 - i));
        ain = cur;
        @(posedge core_clk);
        #1 if (p || i) chk("word", {flag, code}, f(prev));
        if (p || i > 1) chk("capt", cap, f(prev2));
      end
      chk("werr", {12'h000, seen}, {12'h000, p != 0});
      $display("test %0d done", p);
    end
    results;
  end
endmodule // tb_adc_parallel_sample_output

// *** hw/aps_defs.vh ***
`ifndef APS_DEFS_VH
`define APS_DEFS_VH

// ----------------------------------------------------------------------------
// Sample format
// ----------------------------------------------------------------------------
`define APS_CODE_W        12
`define APS_CODE_MAX      12'hfff
`define APS_CODE_ZERO     12'h000
`define APS_OVR_RST       1'b0

// ----------------------------------------------------------------------------
// Analog input as a signed two's complement word from the front end.
// ----------------------------------------------------------------------------
`define APS_IN_W          14
`define APS_OFFSET        14'h0800
`define APS_IN_HI         14'h0fff
`define APS_IN_OVR        14'h1000

// ----------------------------------------------------------------------------
// Clock high width limits on the conversion clock input
// ----------------------------------------------------------------------------
`define APS_CLK_PERIOD_NS 8
`define APS_HIGH_MIN_NS   15
`define APS_HIGH_MAX_NS   300
// Shortest and longest legal high phase in core clock cycles, sized to the
// phase counter: 15 ns rounds up and 300 ns rounds down on the 8 ns clock.
`define APS_HIGH_MIN_CYC  6'h02
`define APS_HIGH_MAX_CYC  6'h25
`define APS_CNT_W         6

`endif

// *** hw/aps_quantizer.v ***
`timescale 1ns/100ps
`include "aps_defs.vh"

// ----------------------------------------------------------------------------
// Maps a signed input word to a straight binary code and overrange flag.
// ----------------------------------------------------------------------------
module aps_quantizer (
  input  wire [`APS_IN_W-1:0]   analog_sample_input,
  output reg  [`APS_CODE_W-1:0] code,
  output reg                    over
);

  reg [`APS_IN_W-1:0] shifted;

  always @* begin
    shifted = analog_sample_input + `APS_OFFSET;
    over    = 1'b0;
    code    = `APS_CODE_ZERO;
    if (analog_sample_input[`APS_IN_W-1]) begin
      if (!shifted[`APS_IN_W-1]) begin
        code = shifted[`APS_CODE_W-1:0];
      end
    end else if (shifted >= `APS_IN_OVR) begin
      over = 1'b1;
      code = `APS_CODE_MAX;
    end else begin
      code = shifted[`APS_CODE_W-1:0];
    end
  end

endmodule // aps_quantizer

// *** hw/aps_top.v ***
`timescale 1ns/100ps
`include "aps_defs.vh"

module aps_top (
  input  wire                   core_clk,
  input  wire                   rst,
  input  wire                   conv_clk,
  input  wire [`APS_IN_W-1:0]   analog_sample_input,
  output reg  [`APS_CODE_W-1:0] sample_code_bits,
  output reg                    overrange_flag,
  output reg                    clock_high_width_err
);

  // --------------------------------------------------------------------------
  // Local constants
  // --------------------------------------------------------------------------
  // Phase of the conversion clock as seen on core_clk.
  localparam [1:0]            PH_LOW   = 2'h0;
  localparam [1:0]            PH_HIGH  = 2'h1;
  localparam [1:0]            PH_LONG  = 2'h2;
  localparam [`APS_CNT_W-1:0] CNT_ZERO = {`APS_CNT_W{1'b0}};
  localparam [`APS_CNT_W-1:0] CNT_ONE  = {{(`APS_CNT_W-1){1'b0}}, 1'b1};
  localparam [`APS_CNT_W-1:0] CNT_TOP  = {`APS_CNT_W{1'b1}};

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg                    conv_q;
  reg                    conv_d;
  wire                   rise;
  wire                   fall;
  wire [`APS_CODE_W-1:0] q_code;
  wire                   q_over;
  reg  [`APS_CODE_W-1:0] samp_code_q;
  reg  [`APS_CODE_W-1:0] samp_code_d;
  reg                    samp_over_q;
  reg                    samp_over_d;
  reg  [`APS_CODE_W-1:0] out_code_d;
  reg                    out_over_d;
  reg  [1:0]             ph_q;
  reg  [1:0]             ph_d;
  reg  [`APS_CNT_W-1:0]  high_cnt_q;
  reg  [`APS_CNT_W-1:0]  high_cnt_d;
  reg                    err_d;

  // --------------------------------------------------------------------------
  // Counter helpers
  // --------------------------------------------------------------------------
  // Counts up by one and sticks at the top value, so a stuck-high clock
  // never wraps back into the legal range.
  function [`APS_CNT_W-1:0] cnt_step;
    input [`APS_CNT_W-1:0] cnt;
    begin
      if (cnt == CNT_TOP) begin
        cnt_step = CNT_TOP;
      end else begin
        cnt_step = cnt + CNT_ONE;
      end
    end
  endfunction

  // True once a high phase has lasted past the longest legal width.
  function cnt_is_long;
    input [`APS_CNT_W-1:0] cnt;
    begin
      cnt_is_long = (cnt >= `APS_HIGH_MAX_CYC);
    end
  endfunction

  // True while a high phase is still shorter than the shortest legal width.
  function cnt_is_short;
    input [`APS_CNT_W-1:0] cnt;
    begin
      cnt_is_short = (cnt < `APS_HIGH_MIN_CYC);
    end
  endfunction

  // True in either of the high phase states.
  function ph_is_high;
    input [1:0] ph;
    begin
      ph_is_high = (ph == PH_HIGH) || (ph == PH_LONG);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Conversion clock edge detection
  // --------------------------------------------------------------------------
  // The detector resets low, so a clock that is already high when reset
  // lifts gives one rise at the first edge after release.
  assign rise = conv_clk & ~conv_q;
  assign fall = ~conv_clk & conv_q;

  always @* begin
    conv_d = conv_clk;
  end

  always @(posedge core_clk) begin
    if (rst) begin
      conv_q <= 1'b0;
    end else begin
      conv_q <= conv_d;
    end
  end

  // --------------------------------------------------------------------------
  // Quantizer
  // --------------------------------------------------------------------------
  aps_quantizer u_quant (
    .analog_sample_input (analog_sample_input),
    .code                (q_code),
    .over                (q_over)
  );

  // --------------------------------------------------------------------------
  // Sample pipeline
  // --------------------------------------------------------------------------
  // The held sample moves to the pins at the next rise, so the word seen after
  // each rise belongs to the rise before it, except the first rise after reset, which shows the zero reset word.
  always @* begin
    samp_code_d = samp_code_q;
    samp_over_d = samp_over_q;
    out_code_d  = sample_code_bits;
    out_over_d  = overrange_flag;
    if (rise) begin
      samp_code_d = q_code;
      samp_over_d = q_over;
      out_code_d  = samp_code_q;
      out_over_d  = samp_over_q;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      samp_code_q      <= `APS_CODE_ZERO;
      samp_over_q      <= `APS_OVR_RST;
      sample_code_bits <= `APS_CODE_ZERO;
      overrange_flag   <= `APS_OVR_RST;
    end else begin
      samp_code_q      <= samp_code_d;
      samp_over_q      <= samp_over_d;
      sample_code_bits <= out_code_d;
      overrange_flag   <= out_over_d;
    end
  end

  // --------------------------------------------------------------------------
  // Conversion clock phase tracking
  // --------------------------------------------------------------------------
  // The long state marks a high phase that has already outlasted the legal
  // width, so the counter stops and the violation is reported once.
  always @* begin
    ph_d = ph_q;
    case (ph_q)
      PH_LOW: begin
        if (rise) begin
          ph_d = PH_HIGH;
        end
      end
      PH_HIGH: begin
        if (!conv_clk) begin
          ph_d = PH_LOW;
        end else if (cnt_is_long(high_cnt_q)) begin
          ph_d = PH_LONG;
        end
      end
      PH_LONG: begin
        if (!conv_clk) begin
          ph_d = PH_LOW;
        end
      end
      default: begin
        ph_d = PH_LOW;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      ph_q <= PH_LOW;
    end else begin
      ph_q <= ph_d;
    end
  end

  // --------------------------------------------------------------------------
  // Clock high width monitor
  // --------------------------------------------------------------------------
  // The far side owns this timing; the flag only reports a violation and
  // clears itself at the next rise.
  always @* begin
    high_cnt_d = high_cnt_q;
    err_d      = clock_high_width_err;
    if (rise) begin
      high_cnt_d = CNT_ONE;
      err_d      = 1'b0;
    end else if (conv_clk && (ph_q == PH_HIGH)) begin
      high_cnt_d = cnt_step(high_cnt_q);
      if (cnt_is_long(high_cnt_q)) begin
        err_d = 1'b1;
      end
    end else if (fall && ph_is_high(ph_q) && cnt_is_short(high_cnt_q)) begin
      err_d = 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      high_cnt_q           <= CNT_ZERO;
      clock_high_width_err <= 1'b0;
    end else begin
      high_cnt_q           <= high_cnt_d;
      clock_high_width_err <= err_d;
    end
  end

endmodule // aps_top
